// >>> hdl/lerpm_map.vh
`ifndef LERPM_MAP_VH
`define LERPM_MAP_VH

// ************************************************************
// Register offsets
// ************************************************************
`define LERPM_STATUS_ADDR 8'h0C
`define LERPM_SOFT_RESET_ADDR 8'h0D
`define LERPM_OUTPUT_PIN_CONTROL_ADDR 8'h0E
`define LERPM_RED_BASE 8'h10
`define LERPM_GREEN_BASE 8'h30
`define LERPM_BLUE_BASE 8'h50
`define LERPM_STORE_END 8'h6F

// ************************************************************
// Values and field positions
// ************************************************************
`define LERPM_SOFT_RESET_KEY 8'hFF
`define LERPM_CTRL_RESET 8'h00
`define LERPM_STORE_RESET 8'h00
`define LERPM_BIT_VARIANT 7
`define LERPM_BIT_IRQ_SEL 2
`define LERPM_BIT_OUT_LEVEL 1
`define LERPM_BIT_IRQ_LVL 0
`define LERPM_CMDS_PER_CHANNEL 16
`define LERPM_CHANNELS 3
`define LERPM_STORE_BYTES 96

`endif

// >>> hdl/lerpm_top.v
`timescale 1ns/1ps
`include "lerpm_map.vh"

module lerpm_top #(
  // Value of the variant flag is arbitrary
  parameter [0:0] VARIANT_FLAG = 1'b0
)
(
  input wire mclk_i,
  input wire reset_i,
  input wire wr_stb_i,
  input wire rd_stb_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  output reg [7:0] rdata_o,
  output reg ack_o,
  output reg resp_o,
  input wire [2:0] chan_end_i,
  input wire [1:0] fetch_chan_i,
  input wire [3:0] fetch_idx_i,
  output reg [15:0] fetch_cmd_o,
  output reg [2:0] chan_irq_o,
  output reg irq_pin_o,
  output reg irq_pin_oe_o,
  output reg general_output_o
);

  // ************************************************************
  // Address decoding
  // ************************************************************
  // Maps a bus address to a flat store index, or flags a miss.
  function [7:0] store_index;
    input [7:0] a;
    begin
      if (a >= `LERPM_RED_BASE && a <= `LERPM_STORE_END)
        store_index = a - `LERPM_RED_BASE;
      else
        store_index = 8'hFF;
    end
  endfunction

  // ************************************************************
  // Storage and internal state
  // ************************************************************
  reg [7:0] store_mem [0:`LERPM_STORE_BYTES-1];
  reg irq_pin_output_select;
  reg irq_pin_level;
  reg general_output_level;
  reg [2:0] chan_flag;
  reg [7:0] next_rdata;
  reg next_ack;
  reg soft_reset_now;
  wire [7:0] wr_idx;
  wire [7:0] rd_idx;
  wire [6:0] fetch_base;
  wire status_read;
  wire pin_ctrl_read;
  wire pin_ctrl_write;
  wire [2:0] next_chan_flag;
  genvar c;
  integer k;

  assign wr_idx = store_index(addr_i);
  assign rd_idx = store_index(addr_i);
  assign status_read = rd_stb_i && (addr_i == `LERPM_STATUS_ADDR);
  assign pin_ctrl_read = rd_stb_i && (addr_i == `LERPM_OUTPUT_PIN_CONTROL_ADDR);
  assign pin_ctrl_write = wr_stb_i && (addr_i == `LERPM_OUTPUT_PIN_CONTROL_ADDR);
  // Channel c, command n: upper byte at 32c + 2n, lower at 32c + 2n + 1
  assign fetch_base = {fetch_chan_i, fetch_idx_i, 1'b0};

  // ************************************************************
  // Soft reset key
  // ************************************************************
  // The key decode is combinational so the reset lands on the edge that takes the byte
  always @*
  begin
    soft_reset_now = wr_stb_i && (addr_i == `LERPM_SOFT_RESET_ADDR) &&
      (wdata_i == `LERPM_SOFT_RESET_KEY);
  end

  // ************************************************************
  // Read data and acknowledge
  // ************************************************************
  always @*
  begin
    next_rdata = 8'h00;
    next_ack = 1'b1;
    if (soft_reset_now)
      next_ack = 1'b0;
    else if (rd_stb_i)
    begin
      // Write-only and unmapped addresses read back as zero
      if (status_read)
        next_rdata = {5'h00, chan_flag};
      else if (pin_ctrl_read)
      begin
        next_rdata[`LERPM_BIT_VARIANT] = VARIANT_FLAG;
        next_rdata[`LERPM_BIT_IRQ_SEL] = irq_pin_output_select;
        next_rdata[`LERPM_BIT_OUT_LEVEL] = general_output_level;
        next_rdata[`LERPM_BIT_IRQ_LVL] = irq_pin_level;
      end
      else if (rd_idx != 8'hFF)
        next_rdata = store_mem[rd_idx[6:0]];
    end
  end

  always @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      rdata_o <= 8'h00;
      ack_o <= 1'b0;
      resp_o <= 1'b0;
    end
    else
    begin
      // Every taken request is answered; only the reset key is refused
      resp_o <= wr_stb_i | rd_stb_i;
      ack_o <= (wr_stb_i | rd_stb_i) & next_ack;
      rdata_o <= next_rdata;
    end
  end

  // ************************************************************
  // Control and status
  // ************************************************************
  always @(posedge mclk_i)
  begin
    if (reset_i || soft_reset_now)
    begin
      irq_pin_output_select <= 1'b0;
      irq_pin_level <= 1'b0;
      general_output_level <= 1'b0;
      chan_flag <= 3'h0;
    end
    else
    begin
      if (pin_ctrl_write)
      begin
        irq_pin_output_select <= wdata_i[`LERPM_BIT_IRQ_SEL];
        general_output_level <= wdata_i[`LERPM_BIT_OUT_LEVEL];
        irq_pin_level <= wdata_i[`LERPM_BIT_IRQ_LVL];
      end
      chan_flag <= next_chan_flag;
    end
  end

  // ************************************************************
  // Channel flags
  // ************************************************************
  // An end event that meets the clearing read keeps its flag, so no event is lost
  generate
    for (c = 0; c < `LERPM_CHANNELS; c = c + 1)
    begin : g_chan_flag
      assign next_chan_flag[c] = chan_end_i[c] | (chan_flag[c] & ~status_read);
    end
  endgenerate

  // ************************************************************
  // Program stores
  // ************************************************************
  // Resetting 96 bytes in one cycle costs area but matches the forced reset
  always @(posedge mclk_i)
  begin
    if (reset_i || soft_reset_now)
    begin
      for (k = 0; k < `LERPM_STORE_BYTES; k = k + 1)
        store_mem[k] <= `LERPM_STORE_RESET;
    end
    // Writes outside the three windows change nothing
    else if (wr_stb_i && wr_idx != 8'hFF)
      store_mem[wr_idx[6:0]] <= wdata_i;
  end

  // ************************************************************
  // Pins and fetch port
  // ************************************************************
  always @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      fetch_cmd_o <= 16'h0000;
      chan_irq_o <= 3'h0;
      irq_pin_o <= 1'b0;
      irq_pin_oe_o <= 1'b0;
      general_output_o <= 1'b0;
    end
    else
    begin
      // Fetch sees the store as it stood before this edge's host write
      if (fetch_chan_i != 2'h3)
        fetch_cmd_o <= {store_mem[fetch_base], store_mem[fetch_base + 7'h01]};
      else
        // Channel code 3 selects no window and reads as an idle zero
        fetch_cmd_o <= 16'h0000;
      chan_irq_o <= chan_flag;
      general_output_o <= general_output_level;
      // As a general output the pin is driven both high and low
      if (irq_pin_output_select)
      begin
        irq_pin_o <= irq_pin_level;
        irq_pin_oe_o <= 1'b1;
      end
      else
      begin
        // Open drain: pull low while any flag is pending and no status read is being taken
        irq_pin_o <= 1'b0;
        irq_pin_oe_o <= |chan_flag && !status_read;
      end
    end
  end

endmodule

// >>> tb/lerpm_host.sv
`timescale 1ns/1ps
module lerpm_host (
  input wire mclk_i,
  input wire [7:0] rdata_i,
  input wire ack_i,
  input wire resp_i,
  output reg wr_o,
  output reg rd_o,
  output reg [7:0] addr_o,
  output reg [7:0] wdata_o
);
  reg tmo = 1'b0;
  integer i;
  initial {wr_o, rd_o, addr_o, wdata_o} = 18'h0;
  // ****
  // One byte access; released lines show the inverse so stale values never pass
  // ****
  task xfer(input w, input [7:0] a, input [7:0] d, output [7:0] q, output k);
    begin
      @(negedge mclk_i);
      {wr_o, rd_o, addr_o, wdata_o} = {w, !w, a, d};
      @(negedge mclk_i);
      {wr_o, rd_o, addr_o, wdata_o} = {2'b00, ~a, ~d};
      for (i = 0; i < 4 && resp_i !== 1'b1; i = i + 1) @(negedge mclk_i);
      q = rdata_i;
      k = ack_i;
      if (resp_i !== 1'b1) tmo = 1;
    end
  endtask
endmodule

// >>> tb/lerpm_props.sv
`timescale 1ns/1ps
// ****
// Bus and pin checks
// ****
module lerpm_props (
  input wire mclk_i,
  input wire reset_i,
  input wire wr_stb_i,
  input wire rd_stb_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire ack_o,
  input wire resp_o,
  input wire [2:0] chan_end_i,
  input wire [2:0] chan_irq_o,
  input wire irq_pin_o,
  input wire irq_pin_oe_o,
  input wire general_output_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  wire sr = wr_stb_i && addr_i == 8'h0D;
  wire pc = wr_stb_i && addr_i == 8'h0E;
  a_key_nack: assert property (sr && wdata_i == 8'hFF |=> resp_o && !ack_o)
    else $error("reset key acknowledged");
  a_other_ack: assert property (sr && wdata_i != 8'hFF |=> resp_o && ack_o)
    else $error("reset register byte refused");
  a_key_clear: assert property (sr && wdata_i == 8'hFF && chan_end_i == 3'h0
    ##1 chan_end_i == 3'h0 |=> !general_output_o && chan_irq_o == 3'h0)
    else $error("soft reset left state");
  a_out_level: assert property (pc ##1 !wr_stb_i
    |=> general_output_o == $past(wdata_i[1], 2)) else $error("output level wrong");
  a_irq_as_out: assert property (pc && wdata_i[2] ##1 !wr_stb_i
    |=> (irq_pin_oe_o ? irq_pin_o : 1'b1) == $past(wdata_i[0], 2)) else $error("pin level");
  a_status_clear: assert property (rd_stb_i && addr_i == 8'h0C && chan_end_i == 3'h0
    ##1 chan_end_i == 3'h0 |=> chan_irq_o == 3'h0) else $error("flags kept");
  a_flag_set: assert property (chan_end_i != 3'h0
    |=> ##1 (chan_irq_o & $past(chan_end_i, 2)) == $past(chan_end_i, 2)) else $error("flag lost");
  a_write_resp: assert property (wr_stb_i && addr_i != 8'h0D |=> resp_o && ack_o)
    else $error("write not answered");
endmodule

// >>> tb/lerpm_top_tb_top.sv
`timescale 1ns/1ps
module lerpm_top_tb_top;
  reg mclk_i = 1'b0;
  reg reset_i = 1'b1;
  reg [2:0] chan_end_i = 3'h0;
  reg [1:0] fetch_chan_i = 2'h3;
  reg [3:0] fetch_idx_i = 4'h0;
  wire wr, rd, k, r, ip, ioe, go;
  wire [7:0] a, d, q;
  wire [15:0] cmd;
  wire [2:0] ci;
  wire irq_wire = ioe ? ip : 1'b1;
  integer num_errors = 0, check_count = 0, c, n;
  reg [7:0] rv, eh, el, ba;
  reg rk;
  initial forever #25 mclk_i = ~mclk_i;
  lerpm_host lerpm_host_i (.mclk_i(mclk_i), .rdata_i(q), .ack_i(k), .resp_i(r), .wr_o(wr),
    .rd_o(rd), .addr_o(a), .wdata_o(d));
  lerpm_top lerpm_top_i (.mclk_i(mclk_i), .reset_i(reset_i), .wr_stb_i(wr), .rd_stb_i(rd),
    .addr_i(a), .wdata_i(d), .rdata_o(q), .ack_o(k), .resp_o(r), .chan_end_i(chan_end_i),
    .fetch_chan_i(fetch_chan_i), .fetch_idx_i(fetch_idx_i), .fetch_cmd_o(cmd),
    .chan_irq_o(ci), .irq_pin_o(ip), .irq_pin_oe_o(ioe), .general_output_o(go));
  task cmp(input [15:0] got, input [15:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp)
      begin
        num_errors = num_errors + 1;
        $display("BAD %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task io(input w, input [7:0] ad, input [7:0] wd);
    begin
      lerpm_host_i.xfer(w, ad, wd, rv, rk);
      if (lerpm_host_i.tmo !== 1'b0)
      begin
        num_errors = num_errors + 1;
        end_of_test;
      end
    end
  endtask
  // ****
  // Main sequence
  // ****
  initial
  begin
    repeat (16) @(negedge mclk_i);
    reset_i = 1'b0;
    io(1'b0, 8'h0E, 8'h00);
    cmp(16'(rv), 16'h0000);
    for (c = 0; c < 3; c = c + 1)
      for (n = 0; n < 16; n = n + 15)
      begin
        ba = 8'(8'h10 + c * 32 + 2 * n);
        eh = 8'(8'hA0 + n);
        el = 8'(8'h50 + c);
        io(1'b1, ba, eh);
        io(1'b1, ba + 8'h01, el);
        fetch_chan_i = 2'(c);
        fetch_idx_i = 4'(n);
        @(negedge mclk_i);
        cmp(cmd, {eh, el});
        io(1'b0, ba + 8'h01, 8'h00);
        cmp(16'(rv), 16'(el));
        io(1'b0, ba, 8'h00);
        cmp(16'(rv), 16'(eh));
      end
    fetch_chan_i = 2'h3;
    @(negedge mclk_i);
    cmp(cmd, 16'h0000);
    io(1'b1, 8'h0E, 8'h07);
    @(negedge mclk_i);
    cmp(16'({go, ioe, irq_wire}), 16'h0007);
    io(1'b1, 8'h0E, 8'h04);
    @(negedge mclk_i);
    cmp(16'({go, ioe, irq_wire}), 16'h0002);
    io(1'b1, 8'h0E, 8'h02);
    chan_end_i = 3'h5;
    @(negedge mclk_i);
    chan_end_i = 3'h0;
    @(negedge mclk_i);
    cmp(16'({ioe, irq_wire}), 16'h0002);
    io(1'b0, 8'h0C, 8'h00);
    cmp(16'(rv), 16'h0005);
    @(negedge mclk_i);
    cmp(16'({ioe, ci}), 16'h0000);
    io(1'b1, 8'h0D, 8'h5A);
    cmp(16'(rk), 16'h0001);
    io(1'b0, 8'h10, 8'h00);
    cmp(16'(rv), 16'h00A0);
    io(1'b0, 8'h0E, 8'h00);
    cmp(16'({go, rv}), 16'h0102);
    chan_end_i = 3'h2;
    @(negedge mclk_i);
    chan_end_i = 3'h0;
    io(1'b1, 8'h0D, 8'hFF);
    cmp(16'(rk), 16'h0000);
    io(1'b0, 8'h10, 8'h00);
    cmp(16'(rv), 16'h0000);
    io(1'b0, 8'h0E, 8'h00);
    cmp(16'({go, ioe, ci, rv}), 16'h0000);
    end_of_test;
  end
endmodule
bind lerpm_top lerpm_props lerpm_props_i (.mclk_i(mclk_i), .reset_i(reset_i),
  .wr_stb_i(wr_stb_i), .rd_stb_i(rd_stb_i), .addr_i(addr_i), .wdata_i(wdata_i), .ack_o(ack_o),
  .resp_o(resp_o), .chan_end_i(chan_end_i), .chan_irq_o(chan_irq_o), .irq_pin_o(irq_pin_o),
  .irq_pin_oe_o(irq_pin_oe_o), .general_output_o(general_output_o));
